/* File: common/tmr2_pkg.sv */
// Package with register map, field layout and constants of the auto-reload timer
package tmr2_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0] ADDR_MODE    = 4'h0;
   localparam logic [3:0] ADDR_CTRL    = 4'h1;
   localparam logic [3:0] ADDR_RLD_LO  = 4'h2;
   localparam logic [3:0] ADDR_RLD_HI  = 4'h3;
   localparam logic [3:0] ADDR_PRESC   = 4'h4;
   localparam logic [3:0] ADDR_CNT_LO  = 4'h5;
   localparam logic [3:0] ADDR_CNT_HI  = 4'h6;
   localparam logic [3:0] ADDR_STATUS  = 4'h7;
   localparam logic [3:0] ADDR_MASK    = 4'h8;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int MODE_DOWN_COUNT_ENABLE_BIT  = 0;
   localparam int MODE_CM_LO     = 1;
   localparam int MODE_CM_HI     = 2;
   localparam int CTRL_RUN_BIT   = 0;
   localparam int CTRL_EXEN_BIT  = 1;
   localparam int ST_OVF_BIT     = 0;
   localparam int ST_EXT_BIT     = 1;

   // ****************************************
   // Values
   // ****************************************
   localparam logic [15:0] CNT_MIN   = 16'h0000;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [15:0] CNT_ONE   = 16'h0001;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [1:0]  CM_BOTTOM_MAX = 2'b00;
   localparam logic [1:0]  CM_MIN_TOP    = 2'b01;
endpackage : tmr2_pkg

/* File: rtl/tmr2_sync.sv */
// Two-flop synchroniser for one pin
`timescale 1ns/1ps
module tmr2_sync (
   // Clock and reset
   input  wire logic CLK_SYS,
   input  wire logic ARST_N,
   // Data
   input  wire logic d_in,
   output logic      q_out
);
   logic stage1_reg;
   logic stage2_reg;

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
      end else begin
         stage1_reg <= d_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign q_out = stage2_reg;
endmodule : tmr2_sync

/* File: rtl/tmr2_presc.sv */
// Prescaler giving one tick every setting+1 clocks
`timescale 1ns/1ps
module tmr2_presc (
   // Clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       ARST_N,
   // Control
   input  wire logic       run,
   input  wire logic [7:0] setting,
   // Tick
   output logic            tick
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      if (!run) begin
         cnt_next = tmr2_pkg::BYTE_ZERO;
      end else if (cnt_reg >= setting) begin
         cnt_next = tmr2_pkg::BYTE_ZERO;
      end else begin
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_reg <= tmr2_pkg::BYTE_ZERO;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick = run && (cnt_reg >= setting);
endmodule : tmr2_presc

/* File: rtl/tmr2_timer.sv */
// 16-bit auto-reload timer with register port and interrupt
// How it works
// - Down-count enable resets to zero, so counting is upward by default.
// - With down-count enable set, direction pin low counts down, high up.
// - Mode 00 up: count to all ones, overflow sets flag, reload from pair.
// - Mode 00 with external enable and down-count enable clear: pin falling edge reloads and sets event flag.
// - Overflow and external event flags both can raise the interrupt.
// - Mode 01 up: count zero to top, overflow sets flag and returns to zero.
// - Mode 01 with external enable and down-count enable clear: pin falling edge clears count, sets event flag.
// - Top value is double-buffered, taking effect after the next overflow in mode 01, at the next bottom in modes 10 and 11.
// - Mode 00 down: count from all ones to reload, underflow back to all ones.
// - Mode 00 enabled, pin high: count reload to all ones, overflow to reload.
// - Mode 01 enabled, pin high: count zero to top, overflow to zero.
// - Modes 10 and 11 count zero to top and back, ignoring direction.
// - Mode 00 period is (65536 - reload) times (prescaler + 1) clocks.
// - Mode 01 period is (top + 1) times (prescaler + 1) clocks.
`timescale 1ns/1ps
module tmr2_timer (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        ARST_N,
   // Register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   // Pin
   input  wire logic        EXT_DIRECTION_TRIGGER_PIN,
   // Interrupt and status
   output logic             IRQ,
   output logic      [15:0] COUNT
);
   // ****************************************
   // Pin synchroniser and prescaler
   // ****************************************
   logic pin_sync;
   logic pin_prev_reg;
   logic tick;
   logic [2:0]  timer_two_mode_reg;
   logic [2:0]  mode_next;
   logic [1:0]  ctrl_reg;
   logic [1:0]  ctrl_next;
   logic [7:0]  reload_low_byte;
   logic [7:0]  reload_high_byte;
   logic [7:0]  rld_lo_next;
   logic [7:0]  rld_hi_next;
   logic [7:0]  timer_prescaler;
   logic [7:0]  presc_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [15:0] top_reg;
   logic [15:0] top_next;
   typedef enum logic [1:0] {
      TMR2_PH_UP   = 2'b01,
      TMR2_PH_DOWN = 2'b10
   } tmr2_phase_e;
   tmr2_phase_e phase_reg;
   tmr2_phase_e phase_next;
   logic [1:0]  status_reg;
   logic [1:0]  status_next;
   logic [1:0]  mask_reg;
   logic [1:0]  mask_next;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;

   tmr2_sync u_sync (
      .CLK_SYS (CLK_SYS),
      .ARST_N  (ARST_N),
      .d_in    (EXT_DIRECTION_TRIGGER_PIN),
      .q_out   (pin_sync)
   );

   tmr2_presc u_presc (
      .CLK_SYS (CLK_SYS),
      .ARST_N  (ARST_N),
      .run     (ctrl_reg[tmr2_pkg::CTRL_RUN_BIT]),
      .setting (timer_prescaler),
      .tick    (tick)
   );

   // ****************************************
   // Decoded controls
   // ****************************************
   logic        down_count_enable;
   logic [1:0]  count_mode_select;
   logic        external_event_enable;
   logic [15:0] reload_val;
   logic        pin_fall;
   logic        count_down;
   logic        ovf_evt;
   logic        ext_evt;

   assign down_count_enable     = timer_two_mode_reg[tmr2_pkg::MODE_DOWN_COUNT_ENABLE_BIT];
   assign count_mode_select     = timer_two_mode_reg[tmr2_pkg::MODE_CM_HI:tmr2_pkg::MODE_CM_LO];
   assign external_event_enable = ctrl_reg[tmr2_pkg::CTRL_EXEN_BIT];
   assign reload_val            = {reload_high_byte, reload_low_byte};
   assign pin_fall              = pin_prev_reg && !pin_sync;
   assign count_down            = down_count_enable && !pin_sync;

   // ****************************************
   // Compare and step values
   // ****************************************
   logic [15:0] cnt_inc;
   logic [15:0] cnt_dec;
   logic        at_max;
   logic        at_min;
   logic        at_reload;
   logic        at_top;
   logic        top_is_min;
   logic        reload_is_min;
   logic        mode_bottom_max;
   logic        mode_min_top;
   logic        edge_trigger;

   assign cnt_inc         = cnt_reg + tmr2_pkg::CNT_ONE;
   assign cnt_dec         = cnt_reg - tmr2_pkg::CNT_ONE;
   assign at_max          = (cnt_reg == tmr2_pkg::CNT_MAX);
   assign at_min          = (cnt_reg == tmr2_pkg::CNT_MIN);
   assign at_reload       = (cnt_reg == reload_val);
   assign at_top          = (cnt_reg >= top_reg);
   assign top_is_min      = (top_reg == tmr2_pkg::CNT_MIN);
   assign reload_is_min   = (reload_val == tmr2_pkg::CNT_MIN);
   assign mode_bottom_max = (count_mode_select == tmr2_pkg::CM_BOTTOM_MAX);
   assign mode_min_top    = (count_mode_select == tmr2_pkg::CM_MIN_TOP);
   assign edge_trigger    = external_event_enable && pin_fall && !down_count_enable;

   // ****************************************
   // Counter next state
   // ****************************************
   always_comb begin
      cnt_next   = cnt_reg;
      top_next   = top_reg;
      phase_next = phase_reg;
      ovf_evt    = 1'b0;
      ext_evt    = 1'b0;
      if (mode_bottom_max) begin
         if (edge_trigger) begin
            cnt_next = reload_val;
            ext_evt  = 1'b1;
         end else if (tick) begin
            if (count_down) begin
               if (at_reload) begin
                  cnt_next = tmr2_pkg::CNT_MAX;
                  ovf_evt  = 1'b1;
               end else begin
                  cnt_next = cnt_dec;
               end
            end else if (at_max) begin
               cnt_next = reload_val;
               ovf_evt  = 1'b1;
            end else begin
               cnt_next = cnt_inc;
            end
         end
      end else if (mode_min_top) begin
         if (edge_trigger) begin
            cnt_next = tmr2_pkg::CNT_MIN;
            ext_evt  = 1'b1;
         end else if (tick) begin
            if (count_down) begin
               if (at_min) begin
                  top_next = reload_val;
                  cnt_next = reload_val;
                  ovf_evt  = 1'b1;
               end else begin
                  cnt_next = cnt_dec;
               end
            end else if (at_top) begin
               top_next = reload_val;
               cnt_next = tmr2_pkg::CNT_MIN;
               ovf_evt  = 1'b1;
            end else begin
               cnt_next = cnt_inc;
            end
         end
      end else if (tick) begin
         // Up-down between min and top, direction pin ignored
         case (phase_reg)
            TMR2_PH_UP: begin
               if (at_top) begin
                  phase_next = TMR2_PH_DOWN;
                  cnt_next   = top_is_min ? top_reg : cnt_dec;
                  ovf_evt    = 1'b1;
               end else begin
                  cnt_next = cnt_inc;
               end
            end
            TMR2_PH_DOWN: begin
               if (at_min) begin
                  phase_next = TMR2_PH_UP;
                  top_next   = reload_val;
                  cnt_next   = reload_is_min ? cnt_reg : tmr2_pkg::CNT_ONE;
               end else begin
                  cnt_next = cnt_dec;
               end
            end
            default: begin
               phase_next = TMR2_PH_UP;
            end
         endcase
      end
   end

   // ****************************************
   // Register port
   // ****************************************
   always_comb begin
      mode_next   = timer_two_mode_reg;
      ctrl_next   = ctrl_reg;
      rld_lo_next = reload_low_byte;
      rld_hi_next = reload_high_byte;
      presc_next  = timer_prescaler;
      mask_next   = mask_reg;
      status_next = status_reg;
      rdata_next  = tmr2_pkg::BYTE_ZERO;
      if (WR) begin
         if (ADDR == tmr2_pkg::ADDR_MODE) begin
            mode_next = WDATA[2:0];
         end else if (ADDR == tmr2_pkg::ADDR_CTRL) begin
            ctrl_next = WDATA[1:0];
         end else if (ADDR == tmr2_pkg::ADDR_RLD_LO) begin
            rld_lo_next = WDATA;
         end else if (ADDR == tmr2_pkg::ADDR_RLD_HI) begin
            rld_hi_next = WDATA;
         end else if (ADDR == tmr2_pkg::ADDR_PRESC) begin
            presc_next = WDATA;
         end else if (ADDR == tmr2_pkg::ADDR_MASK) begin
            mask_next = WDATA[1:0];
         end
      end
      if (RD) begin
         if (ADDR == tmr2_pkg::ADDR_MODE) begin
            rdata_next = {5'h00, timer_two_mode_reg};
         end else if (ADDR == tmr2_pkg::ADDR_CTRL) begin
            rdata_next = {6'h00, ctrl_reg};
         end else if (ADDR == tmr2_pkg::ADDR_RLD_LO) begin
            rdata_next = reload_low_byte;
         end else if (ADDR == tmr2_pkg::ADDR_RLD_HI) begin
            rdata_next = reload_high_byte;
         end else if (ADDR == tmr2_pkg::ADDR_PRESC) begin
            rdata_next = timer_prescaler;
         end else if (ADDR == tmr2_pkg::ADDR_CNT_LO) begin
            rdata_next = cnt_reg[7:0];
         end else if (ADDR == tmr2_pkg::ADDR_CNT_HI) begin
            rdata_next = cnt_reg[15:8];
         end else if (ADDR == tmr2_pkg::ADDR_STATUS) begin
            rdata_next  = {6'h00, status_reg};
            status_next = 2'b00;
         end else if (ADDR == tmr2_pkg::ADDR_MASK) begin
            rdata_next = {6'h00, mask_reg};
         end
      end
      // Set wins over the read clear
      if (ovf_evt) begin
         status_next[tmr2_pkg::ST_OVF_BIT] = 1'b1;
      end
      if (ext_evt) begin
         status_next[tmr2_pkg::ST_EXT_BIT] = 1'b1;
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         timer_two_mode_reg <= 3'b000;
         ctrl_reg           <= 2'b00;
         reload_low_byte    <= tmr2_pkg::BYTE_ZERO;
         reload_high_byte   <= tmr2_pkg::BYTE_ZERO;
         timer_prescaler    <= tmr2_pkg::BYTE_ZERO;
         cnt_reg            <= tmr2_pkg::CNT_MIN;
         top_reg            <= tmr2_pkg::CNT_MIN;
         phase_reg          <= TMR2_PH_UP;
         status_reg         <= 2'b00;
         mask_reg           <= 2'b00;
         rdata_reg          <= tmr2_pkg::BYTE_ZERO;
         pin_prev_reg       <= 1'b0;
      end else begin
         timer_two_mode_reg <= mode_next;
         ctrl_reg           <= ctrl_next;
         reload_low_byte    <= rld_lo_next;
         reload_high_byte   <= rld_hi_next;
         timer_prescaler    <= presc_next;
         cnt_reg            <= cnt_next;
         top_reg            <= top_next;
         phase_reg          <= phase_next;
         status_reg         <= status_next;
         mask_reg           <= mask_next;
         rdata_reg          <= rdata_next;
         pin_prev_reg       <= pin_sync;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic overflow_flag;
   logic external_event_flag;

   assign overflow_flag       = status_reg[tmr2_pkg::ST_OVF_BIT];
   assign external_event_flag = status_reg[tmr2_pkg::ST_EXT_BIT];
   assign RDATA               = rdata_reg;
   assign COUNT               = cnt_reg;
   assign IRQ                 = (overflow_flag && mask_reg[tmr2_pkg::ST_OVF_BIT])
                                || (external_event_flag && mask_reg[tmr2_pkg::ST_EXT_BIT]);
endmodule : tmr2_timer

/* File: tb/tmr2_pin_model.sv */
// Model of the pin source giving direction and trigger
`timescale 1ns/1ps
module tmr2_pin_model (
   // Pin
   output logic pin
);
   initial pin = 1'b1;
   // Level set at once with a nonblocking assignment, no clock edge awaited; low level gives the falling edge
   task automatic set_lvl(input logic v);
      pin <= v;
   endtask : set_lvl
endmodule : tmr2_pin_model

/* File: tb/tmr2_timer_properties.sv */
// Checker of the timer port behaviour
`timescale 1ns/1ps
module tmr2_timer_properties (
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        ARST_N,
   // Register port
   input wire logic [3:0]  ADDR,
   input wire logic [7:0]  WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [7:0]  RDATA,
   // Pin and outputs
   input wire logic        EXT_DIRECTION_TRIGGER_PIN,
   input wire logic        IRQ,
   input wire logic [15:0] COUNT
);
   // ****************************************
   // Register shadow
   // ****************************************
   logic [2:0]  mode_reg, mode_next;
   logic [7:0]  presc_reg, presc_next;
   logic [15:0] rld_reg, rld_next;
   logic [1:0]  mask_reg, mask_next;
   always_comb begin
      mode_next = mode_reg;
      presc_next = presc_reg;
      rld_next = rld_reg;
      mask_next = mask_reg;
      if (WR) begin
         case (ADDR)
            tmr2_pkg::ADDR_MODE: mode_next = WDATA[2:0];
            tmr2_pkg::ADDR_PRESC: presc_next = WDATA;
            tmr2_pkg::ADDR_RLD_LO: rld_next[7:0] = WDATA;
            tmr2_pkg::ADDR_RLD_HI: rld_next[15:8] = WDATA;
            tmr2_pkg::ADDR_MASK: mask_next = WDATA[1:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_reg <= 3'h0;
         presc_reg <= 8'h00;
         rld_reg <= 16'h0000;
         mask_reg <= 2'h0;
      end else begin
         mode_reg <= mode_next;
         presc_reg <= presc_next;
         rld_reg <= rld_next;
         mask_reg <= mask_next;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not zero outside read answer");
   AST_UP_STEP: assert property (mode_reg == 3'h0 && COUNT != 16'hFFFF |=> COUNT == $past(COUNT)
      || COUNT == $past(COUNT) + 16'h0001 || COUNT == $past(rld_reg))
      else $error("bad up step");
   AST_UP_RELOAD: assert property (mode_reg == 3'h0 && COUNT == 16'hFFFF |=> COUNT == 16'hFFFF
      || COUNT == $past(rld_reg))
      else $error("bad reload after all ones");
   AST_TOP_WRAP: assert property (mode_reg == 3'h2 |=> COUNT == $past(COUNT)
      || COUNT == $past(COUNT) + 16'h0001 || COUNT == 16'h0000)
      else $error("bad step in top mode");
   AST_PRESC_GAP: assert property (mode_reg[0] && presc_reg == 8'h01 && $changed(COUNT)
      |=> $stable(COUNT))
      else $error("count moved faster than prescaler");
   AST_MASK_GATE: assert property (mask_reg == 2'h0 |-> !IRQ)
      else $error("interrupt while fully masked");
   AST_IRQ_STICKY: assert property (IRQ && !WR && !(RD && ADDR == tmr2_pkg::ADDR_STATUS) |=> IRQ)
      else $error("flag dropped without read");
   AST_UPDOWN_STEP: assert property (mode_reg[2] |=> COUNT == $past(COUNT)
      || COUNT == $past(COUNT) + 16'h0001 || COUNT == $past(COUNT) - 16'h0001)
      else $error("bad step in up-down mode");
endmodule : tmr2_timer_properties

/* File: tb/tb.sv */
// Testbench of the auto-reload timer
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0;
   logic        arst_n;
   logic [3:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata, d;
   logic        pin, irq;
   logic [15:0] count;
   int          errors = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          t0, t1;
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   tmr2_pin_model u_pin (.pin(pin));
   tmr2_timer uut (.CLK_SYS(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .EXT_DIRECTION_TRIGGER_PIN(pin), .IRQ(irq), .COUNT(count));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic stop_test();
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(posedge clk);
   endtask : rd_reg
   task automatic ovf(output int t);
      int n;
      rd_reg(tmr2_pkg::ADDR_STATUS, d);
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 5000) begin
         errors++;
      end
      t = cyc;
      @(posedge clk);
   endtask : ovf
   task automatic step(input logic [15:0] v, input logic [15:0] exp);
      int n;
      n = 0;
      while (count !== v && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 5000) begin
         errors++;
      end
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(count, exp);
      @(posedge clk);
   endtask : step
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test();
   end
   initial begin
      arst_n <= 1'b0;
      addr   <= 4'h0;
      wdata  <= 8'h00;
      wr     <= 1'b0;
      rd     <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 16; a++) begin
         rd_reg(4'(a), d);
         chk({8'h00, d}, 16'h0000);
      end
      wr_reg(tmr2_pkg::ADDR_RLD_LO, 8'hF0);
      wr_reg(tmr2_pkg::ADDR_RLD_HI, 8'hFF);
      wr_reg(tmr2_pkg::ADDR_PRESC, 8'h01);
      wr_reg(tmr2_pkg::ADDR_MASK, 8'h03);
      wr_reg(tmr2_pkg::ADDR_CTRL, 8'h03);
      u_pin.set_lvl(1'b0);
      ovf(t0);
      u_pin.set_lvl(1'b1);
      @(negedge clk);
      chk({8'h00, count[15:8]}, 16'h00FF);
      @(posedge clk);
      rd_reg(tmr2_pkg::ADDR_STATUS, d);
      chk({8'h00, d}, 16'h0002);
      ovf(t0);
      ovf(t1);
      chk(16'(t1 - t0), 16'h0020);
      wr_reg(tmr2_pkg::ADDR_MASK, 8'h00);
      repeat (80) @(posedge clk);
      rd_reg(tmr2_pkg::ADDR_STATUS, d);
      chk({8'h00, d}, 16'h0001);
      wr_reg(tmr2_pkg::ADDR_MASK, 8'h03);
      u_pin.set_lvl(1'b0);
      repeat (4) @(posedge clk);
      wr_reg(tmr2_pkg::ADDR_MODE, 8'h01);
      step(16'hFFF5, 16'hFFF4);
      u_pin.set_lvl(1'b1);
      step(16'hFFF5, 16'hFFF6);
      wr_reg(tmr2_pkg::ADDR_PRESC, 8'h00);
      wr_reg(tmr2_pkg::ADDR_RLD_LO, 8'h07);
      wr_reg(tmr2_pkg::ADDR_RLD_HI, 8'h00);
      wr_reg(tmr2_pkg::ADDR_MODE, 8'h02);
      u_pin.set_lvl(1'b0);
      repeat (6) @(posedge clk);
      u_pin.set_lvl(1'b1);
      rd_reg(tmr2_pkg::ADDR_STATUS, d);
      chk({15'h0000, d[1]}, 16'h0001);
      ovf(t0);
      ovf(t1);
      chk(16'(t1 - t0), 16'h0008);
      wr_reg(tmr2_pkg::ADDR_RLD_LO, 8'h03);
      ovf(t0);
      chk(16'(t0 - t1), 16'h0008);
      ovf(t1);
      chk(16'(t1 - t0), 16'h0004);
      u_pin.set_lvl(1'b0);
      wr_reg(tmr2_pkg::ADDR_MODE, 8'h05);
      repeat (40) @(posedge clk);
      wr_reg(tmr2_pkg::ADDR_MODE, 8'h06);
      repeat (40) @(posedge clk);
      chk({15'h0000, count <= 16'h0003}, 16'h0001);
      wr_reg(tmr2_pkg::ADDR_MODE, 8'h03);
      step(16'h0001, 16'h0003);
      u_pin.set_lvl(1'b1);
      repeat (4) @(posedge clk);
      step(16'h0002, 16'h0000);
      stop_test();
   end
endmodule : tb
bind tmr2_timer tmr2_timer_properties u_props (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_DIRECTION_TRIGGER_PIN(EXT_DIRECTION_TRIGGER_PIN), .IRQ(IRQ), .COUNT(COUNT));
